// ==== kmn_pkg.sv ====
package kmn_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_KHZ           = 25000;
    localparam int ESC_HOLD_MS       = 1000;
    localparam int ESC_HOLD_CYCLES   = ESC_HOLD_MS * CLK_KHZ;
    localparam int ESC_REPEAT_MS     = 500;
    localparam int ESC_REPEAT_CYCLES = ESC_REPEAT_MS * CLK_KHZ;
    localparam int HOLD_W            = 25;

    // ------------------------------------------------------------------
    // Keys
    // ------------------------------------------------------------------
    localparam int NUM_KEYS = 4;
    localparam int KEY_ESC  = 0;
    localparam int KEY_SET  = 1;
    localparam int KEY_UP   = 2;
    localparam int KEY_DOWN = 3;

    // ------------------------------------------------------------------
    // Code space and storage
    // ------------------------------------------------------------------
    localparam int GRP_W    = 3;
    localparam int IDX_W    = 3;
    localparam int ADDR_W   = GRP_W + IDX_W;
    localparam int ENTRIES  = 64;
    localparam int DATA_W   = 16;
    localparam int DIGITS   = 4;
    localparam int CHAR_W   = 5;
    localparam int DISP_W   = DIGITS * CHAR_W;

    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    // Group order is also the stepping order of the escape key.
    localparam logic [GRP_W-1:0] GRP_MON   = 3'h0;
    localparam logic [GRP_W-1:0] GRP_MAIN  = 3'h1;
    localparam logic [GRP_W-1:0] GRP_STD   = 3'h2;
    localparam logic [GRP_W-1:0] GRP_FINE  = 3'h3;
    localparam logic [GRP_W-1:0] GRP_TERM  = 3'h4;
    localparam logic [GRP_W-1:0] GRP_MOTOR = 3'h5;
    localparam logic [GRP_W-1:0] GRP_PULSE = 3'h6;
    localparam logic [GRP_W-1:0] GRP_USER  = 3'h7;

    localparam logic [IDX_W-1:0] FIRST_MON_IDX      = 3'h0;
    localparam logic [IDX_W-1:0] EXCEPTED_PROFILE_IDX = 3'h3;

    // Characters 0x00..0x09 are digits; group letters follow in group order.
    localparam logic [CHAR_W-1:0] CH_LETTER_BASE = 5'h0A;

    function automatic logic [DATA_W-1:0] bcdStep(input logic [DATA_W-1:0] v, input logic up);
        logic [DATA_W-1:0] r;
        logic              carry;
        logic [3:0]        d;
        r     = v;
        carry = 1'b1;
        for (int i = 0; i < DIGITS; i++)
        begin
            d = v[4*i +: 4];
            if (carry)
            begin
                if (up)
                begin
                    carry       = (d == 4'h9);
                    r[4*i +: 4] = carry ? 4'h0 : d + 4'h1;
                end
                else
                begin
                    carry       = (d == 4'h0);
                    r[4*i +: 4] = carry ? 4'h9 : d - 4'h1;
                end
            end
        end
        return r;
    endfunction

endpackage

// ==== kmn_store_if.sv ====
`timescale 1ns/1ps
interface kmn_store_if;
    logic                       wrEn;
    logic [kmn_pkg::ADDR_W-1:0] wrAddr;
    logic [kmn_pkg::DATA_W-1:0] wrData;
    logic [kmn_pkg::ADDR_W-1:0] rdAddr;
    logic [kmn_pkg::DATA_W-1:0] rdData;

    modport nav   (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
    modport store (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

// ==== kmn_key_sync.sv ====
`timescale 1ns/1ps
module kmn_key_sync (
    input  wire logic                         clock,
    input  wire logic                         sys_rst,
    input  wire logic [kmn_pkg::NUM_KEYS-1:0] keyPin,
    output logic      [kmn_pkg::NUM_KEYS-1:0] keyLevel,
    output logic      [kmn_pkg::NUM_KEYS-1:0] keyPress
);
    genvar k;
    generate
        for (k = 0; k < kmn_pkg::NUM_KEYS; k++)
        begin : g_key
            logic [2:0] syncFf;
            logic [2:0] nxt_sync;
            logic       levelFf;
            logic       nxt_level;
            logic       pressFf;
            logic       nxt_press;

            // A change counts only once the second and third stages agree.
            always_comb
            begin
                nxt_sync  = {syncFf[1:0], keyPin[k]};
                nxt_level = (syncFf[1] == syncFf[2]) ? syncFf[2] : levelFf;
                nxt_press = nxt_level & ~levelFf;
            end

            always_ff @(posedge clock)
            begin
                if (sys_rst)
                begin
                    syncFf  <= 3'h0;
                    levelFf <= 1'b0;
                    pressFf <= 1'b0;
                end
                else
                begin
                    syncFf  <= nxt_sync;
                    levelFf <= nxt_level;
                    pressFf <= nxt_press;
                end
            end

            assign keyLevel[k] = levelFf;
            assign keyPress[k] = pressFf;
        end
    endgenerate
endmodule

// ==== kmn_param_store.sv ====
`timescale 1ns/1ps
module kmn_param_store (
    input  wire logic  clock,
    input  wire logic  sys_rst,
    kmn_store_if.store st
);
    logic [kmn_pkg::DATA_W-1:0] memFf [kmn_pkg::ENTRIES];

    genvar e;
    generate
        for (e = 0; e < kmn_pkg::ENTRIES; e++)
        begin : g_entry
            logic [kmn_pkg::DATA_W-1:0] nxt_mem;

            always_comb
            begin
                nxt_mem = (st.wrEn && st.wrAddr == kmn_pkg::ADDR_W'(e)) ? st.wrData : memFf[e];
            end

            always_ff @(posedge clock)
            begin
                if (sys_rst)
                    memFf[e] <= kmn_pkg::DATA_RST;
                else
                    memFf[e] <= nxt_mem;
            end
        end
    endgenerate

    assign st.rdData = memFf[st.rdAddr];
endmodule

// ==== kmn_navigator.sv ====
// How it works
// - Each function is a four-character code, grouped by its left-most character.
// - Groups are monitor D, then program F A B C H P U; errors unnavigable.
// - Escape on a code display jumps to first code of next group.
// - Escape on a data display drops the edit and returns to the code.
// - Set on a code display shows that code's data.
// - Set on a data display stores the edit and returns to the code.
// - Monitor codes are display-only; edits to them are refused.
// - Main profile codes except the excepted one act at once, without blinking.
// - Escape held over one second forces the first monitor code.
// - While escape is held, groups keep stepping until the one-second jump.
// - Everything is shown on one four-digit display plus keys and indicators.
`timescale 1ns/1ps
module kmn_navigator #(
    parameter int HOLD_CYCLES   = kmn_pkg::ESC_HOLD_CYCLES,
    parameter int REPEAT_CYCLES = kmn_pkg::ESC_REPEAT_CYCLES
) (
    input  wire logic                         clock,
    input  wire logic                         sys_rst,
    input  wire logic                         escKey,
    input  wire logic                         setKey,
    input  wire logic                         upKey,
    input  wire logic                         downKey,
    input  wire logic [kmn_pkg::DATA_W-1:0]   monData,
    output logic      [kmn_pkg::DISP_W-1:0]   dispChars,
    output logic                              showingData,
    output logic                              dataBlink,
    output logic                              programModeIndicator,
    output logic      [kmn_pkg::IDX_W-1:0]    monSelect,
    output logic                              applyStrobe,
    output logic      [kmn_pkg::GRP_W-1:0]    applyGroup,
    output logic      [kmn_pkg::IDX_W-1:0]    applyIndex,
    output logic      [kmn_pkg::DATA_W-1:0]   applyValue
);
    typedef enum logic {ST_CODE, ST_DATA} kmn_state_e;
    // ------------------------------------------------------------------
    // Key conditioning and storage
    // ------------------------------------------------------------------
    logic [kmn_pkg::NUM_KEYS-1:0] keyLevel, keyPress;
    kmn_store_if                  st();

    kmn_key_sync u_keys (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .keyPin   ({downKey, upKey, setKey, escKey}),
        .keyLevel (keyLevel),
        .keyPress (keyPress)
    );

    kmn_param_store u_store (
        .clock   (clock),
        .sys_rst (sys_rst),
        .st      (st.store)
    );

    wire escLevel = keyLevel[kmn_pkg::KEY_ESC];
    wire escPress = keyPress[kmn_pkg::KEY_ESC];
    wire setPress = keyPress[kmn_pkg::KEY_SET];
    wire upPress  = keyPress[kmn_pkg::KEY_UP];
    wire dnPress  = keyPress[kmn_pkg::KEY_DOWN];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    kmn_state_e                  stateFf,   nxt_state;
    logic [kmn_pkg::GRP_W-1:0]   groupFf,   nxt_group;
    logic [kmn_pkg::IDX_W-1:0]   idxFf,     nxt_idx;
    logic [kmn_pkg::DATA_W-1:0]  editFf,    nxt_edit;
    logic [kmn_pkg::DATA_W-1:0]  origFf,    nxt_orig;
    logic [kmn_pkg::HOLD_W-1:0]  holdCntFf, nxt_holdCnt;
    logic [kmn_pkg::HOLD_W-1:0]  repCntFf,  nxt_repCnt;
    logic                        jumpedFf,  nxt_jumped;
    logic                        applyStrobeFf, nxt_applyStrobe;
    logic [kmn_pkg::DATA_W-1:0]  applyValueFf,  nxt_applyValue;
    logic [kmn_pkg::DISP_W-1:0]  dispFf,    nxt_disp;
    logic                        blinkFf,   nxt_blink;
    logic                        pmiFf,     nxt_pmi;

    logic holdEnd, repPulse, escEvent, isMon, immediate;

    always_comb
    begin
        holdEnd   = escLevel && !jumpedFf && holdCntFf == kmn_pkg::HOLD_W'(HOLD_CYCLES - 1);
        repPulse  = escLevel && !jumpedFf && !holdEnd && repCntFf == kmn_pkg::HOLD_W'(REPEAT_CYCLES - 1);
        escEvent  = (escPress || repPulse) && !holdEnd;
        isMon     = (groupFf == kmn_pkg::GRP_MON);
        immediate = (groupFf == kmn_pkg::GRP_MAIN) && (idxFf != kmn_pkg::EXCEPTED_PROFILE_IDX);
    end

    // ------------------------------------------------------------------
    // Escape hold timer
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_holdCnt = holdCntFf;
        nxt_repCnt  = repCntFf;
        nxt_jumped  = jumpedFf;
        if (!escLevel)
        begin
            nxt_holdCnt = '0;
            nxt_repCnt  = '0;
            nxt_jumped  = 1'b0;
        end
        else if (holdEnd)
            nxt_jumped = 1'b1;
        else if (!jumpedFf)
        begin
            nxt_holdCnt = holdCntFf + kmn_pkg::HOLD_W'(1);
            nxt_repCnt  = repPulse ? '0 : repCntFf + kmn_pkg::HOLD_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Navigation
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_state       = stateFf;
        nxt_group       = groupFf;
        nxt_idx         = idxFf;
        nxt_edit        = editFf;
        nxt_orig        = origFf;
        nxt_applyStrobe = 1'b0;
        nxt_applyValue  = applyValueFf;
        st.wrEn         = 1'b0;
        st.wrAddr       = {groupFf, idxFf};
        st.wrData       = editFf;
        st.rdAddr       = {groupFf, idxFf};
        if (holdEnd)
        begin
            // An immediate edit is already live, so it is undone before leaving.
            if (stateFf == ST_DATA && immediate && editFf != origFf)
            begin
                st.wrEn         = 1'b1;
                st.wrData       = origFf;
                nxt_applyStrobe = 1'b1;
                nxt_applyValue  = origFf;
            end
            nxt_state = ST_CODE;
            nxt_group = kmn_pkg::GRP_MON;
            nxt_idx   = kmn_pkg::FIRST_MON_IDX;
        end
        else
        begin
            case (stateFf)
                ST_CODE:
                begin
                    if (escEvent)
                    begin
                        nxt_group = groupFf + kmn_pkg::GRP_W'(1);
                        nxt_idx   = '0;
                    end
                    else if (setPress)
                    begin
                        nxt_state = ST_DATA;
                        nxt_edit  = isMon ? monData : st.rdData;
                        nxt_orig  = isMon ? monData : st.rdData;
                    end
                    else if (upPress)
                        nxt_idx = idxFf + kmn_pkg::IDX_W'(1);
                    else if (dnPress)
                        nxt_idx = idxFf - kmn_pkg::IDX_W'(1);
                end
                ST_DATA:
                begin
                    if (isMon)
                    begin
                        // Monitor data follows the drive; keys cannot change it.
                        nxt_edit = monData;
                        if (escEvent || setPress)
                            nxt_state = ST_CODE;
                    end
                    else if (escEvent)
                    begin
                        nxt_state = ST_CODE;
                        if (immediate && editFf != origFf)
                        begin
                            st.wrEn         = 1'b1;
                            st.wrData       = origFf;
                            nxt_applyStrobe = 1'b1;
                            nxt_applyValue  = origFf;
                        end
                    end
                    else if (setPress)
                    begin
                        nxt_state       = ST_CODE;
                        st.wrEn         = 1'b1;
                        nxt_applyStrobe = 1'b1;
                        nxt_applyValue  = editFf;
                    end
                    else if (upPress || dnPress)
                    begin
                        nxt_edit = kmn_pkg::bcdStep(editFf, upPress);
                        if (immediate)
                        begin
                            st.wrEn         = 1'b1;
                            st.wrData       = nxt_edit;
                            nxt_applyStrobe = 1'b1;
                            nxt_applyValue  = nxt_edit;
                        end
                    end
                end
                default:
                    nxt_state = ST_CODE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Display
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_blink = 1'b0;
        nxt_pmi   = (nxt_group != kmn_pkg::GRP_MON);
        if (nxt_state == ST_DATA)
        begin
            for (int i = 0; i < kmn_pkg::DIGITS; i++)
                nxt_disp[kmn_pkg::CHAR_W*i +: kmn_pkg::CHAR_W] = {1'b0, nxt_edit[4*i +: 4]};
            nxt_blink = (nxt_group != kmn_pkg::GRP_MON)
                     && !(nxt_group == kmn_pkg::GRP_MAIN && nxt_idx != kmn_pkg::EXCEPTED_PROFILE_IDX);
        end
        else
            nxt_disp = {kmn_pkg::CH_LETTER_BASE + {2'b00, nxt_group}, 5'h00, 5'h00,
                        5'({1'b0, nxt_idx} + 4'h1)};
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            stateFf       <= ST_CODE;
            groupFf       <= kmn_pkg::GRP_MON;
            idxFf         <= kmn_pkg::FIRST_MON_IDX;
            editFf        <= kmn_pkg::DATA_RST;
            origFf        <= kmn_pkg::DATA_RST;
            holdCntFf     <= '0;
            repCntFf      <= '0;
            jumpedFf      <= 1'b0;
            applyStrobeFf <= 1'b0;
            applyValueFf  <= kmn_pkg::DATA_RST;
            dispFf        <= {kmn_pkg::CH_LETTER_BASE, 5'h00, 5'h00, 5'h01};
            blinkFf       <= 1'b0;
            pmiFf         <= 1'b0;
        end
        else
        begin
            stateFf       <= nxt_state;
            groupFf       <= nxt_group;
            idxFf         <= nxt_idx;
            editFf        <= nxt_edit;
            origFf        <= nxt_orig;
            holdCntFf     <= nxt_holdCnt;
            repCntFf      <= nxt_repCnt;
            jumpedFf      <= nxt_jumped;
            applyStrobeFf <= nxt_applyStrobe;
            applyValueFf  <= nxt_applyValue;
            dispFf        <= nxt_disp;
            blinkFf       <= nxt_blink;
            pmiFf         <= nxt_pmi;
        end
    end

    // Group and index of an apply equal the code still shown, except a long-escape restore, which reports the first monitor code.
    assign dispChars            = dispFf;
    assign showingData          = (stateFf == ST_DATA);
    assign dataBlink            = blinkFf;
    assign programModeIndicator = pmiFf;
    assign monSelect            = idxFf;
    assign applyStrobe          = applyStrobeFf;
    assign applyGroup           = groupFf;
    assign applyIndex           = idxFf;
    assign applyValue           = applyValueFf;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_esc_step;
        stateFf == ST_CODE && escEvent |=> idxFf == 3'h0 && groupFf == $past(groupFf) + 3'h1;
    endproperty
    a_esc_step: assert property (p_esc_step) else $error("escape did not step group");

    property p_esc_cancel;
        stateFf == ST_DATA && escEvent && !holdEnd |=> stateFf == ST_CODE && $stable(groupFf) && $stable(idxFf);
    endproperty
    a_esc_cancel: assert property (p_esc_cancel) else $error("escape did not cancel edit");

    property p_set_enter;
        stateFf == ST_CODE && setPress && !escEvent && !holdEnd |=> stateFf == ST_DATA;
    endproperty
    a_set_enter: assert property (p_set_enter) else $error("set did not show data");

    property p_set_store;
        stateFf == ST_DATA && !isMon && setPress && !escEvent && !holdEnd
            |-> st.wrEn && st.wrData == editFf ##1 stateFf == ST_CODE && applyStrobe;
    endproperty
    a_set_store: assert property (p_set_store) else $error("set did not store data");

    property p_up_code;
        stateFf == ST_CODE && upPress && !setPress && !escEvent && !holdEnd |=> idxFf == $past(idxFf) + 3'h1;
    endproperty
    a_up_code: assert property (p_up_code) else $error("up did not step code");

    property p_mon_readonly;
        st.wrEn |-> st.wrAddr[5:3] != kmn_pkg::GRP_MON;
    endproperty
    a_mon_readonly: assert property (p_mon_readonly) else $error("monitor code written");

    property p_immediate;
        stateFf == ST_DATA && immediate && (upPress || dnPress) && !setPress && !escEvent && !holdEnd
            |=> applyStrobe && applyValue == editFf && !dataBlink;
    endproperty
    a_immediate: assert property (p_immediate) else $error("main profile edit not applied");

    property p_long_esc;
        holdEnd |=> stateFf == ST_CODE && groupFf == 3'h0 && idxFf == 3'h0 ##1 $stable(groupFf) [*3];
    endproperty
    a_long_esc: assert property (p_long_esc) else $error("long escape did not reach first monitor code");

    property p_hold_bound;
        holdCntFf < kmn_pkg::HOLD_W'(HOLD_CYCLES) && repCntFf < kmn_pkg::HOLD_W'(REPEAT_CYCLES);
    endproperty
    a_hold_bound: assert property (p_hold_bound) else $error("hold counters overran");

    property p_disp_group;
        stateFf == ST_CODE |-> dispChars[19:15] == kmn_pkg::CH_LETTER_BASE + {2'b00, groupFf};
    endproperty
    a_disp_group: assert property (p_disp_group) else $error("display letter not group");

    c_long_esc:  cover property (holdEnd ##1 stateFf == ST_CODE);
    c_store:     cover property (stateFf == ST_DATA && setPress && !isMon);
    c_immediate: cover property (applyStrobe && stateFf == ST_DATA);
    c_repeat:    cover property (repPulse);
endmodule

// ==== kmn_operator.sv ====
`timescale 1ns/1ps
// --------------------------------------------------------------------------
// Front-panel operator
// --------------------------------------------------------------------------
// Keys idle low, as a released button with its pull-down reads.
module kmn_operator (
    input  wire logic clock,
    output logic      escKey,
    output logic      setKey,
    output logic      upKey,
    output logic      downKey
);
    logic [kmn_pkg::NUM_KEYS-1:0] keys = '0;

    assign escKey  = keys[kmn_pkg::KEY_ESC];
    assign setKey  = keys[kmn_pkg::KEY_SET];
    assign upKey   = keys[kmn_pkg::KEY_UP];
    assign downKey = keys[kmn_pkg::KEY_DOWN];

    // Release time covers the sync delay, so every press is a fresh one.
    task automatic press(input int key, input int hold);
        @(negedge clock);
        keys[key] = 1'b1;
        repeat (hold) @(negedge clock);
        keys[key] = 1'b0;
        repeat (10) @(negedge clock);
    endtask
endmodule

// ==== keypad_menu_navigator_tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); end end
module keypad_menu_navigator_tb;
    localparam int ESC = kmn_pkg::KEY_ESC;
    localparam int SET = kmn_pkg::KEY_SET;
    localparam int UP  = kmn_pkg::KEY_UP;
    localparam int DN  = kmn_pkg::KEY_DOWN;
    // Short hold and repeat times keep the run brief; repeat must stay below hold.
    localparam int HOLD_T = 40;
    localparam int REP_T  = 15;

    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        escKey, setKey, upKey, downKey;
    logic [15:0] monData = 16'h0000;
    logic [19:0] dispChars;
    logic        showingData, dataBlink, programModeIndicator, applyStrobe;
    logic [2:0]  monSelect, applyGroup, applyIndex;
    logic [15:0] applyValue;
    logic [21:0] viewQ[$];
    logic [21:0] applyQ[$];
    logic [21:0] prevView, cur, expNote;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          n;

    always #20 clock = ~clock;

    kmn_operator op (.clock(clock), .escKey(escKey), .setKey(setKey), .upKey(upKey), .downKey(downKey));

    kmn_navigator #(.HOLD_CYCLES(HOLD_T), .REPEAT_CYCLES(REP_T)) dut (
        .clock(clock), .sys_rst(sys_rst), .escKey(escKey), .setKey(setKey), .upKey(upKey),
        .downKey(downKey), .monData(monData), .dispChars(dispChars), .showingData(showingData),
        .dataBlink(dataBlink), .programModeIndicator(programModeIndicator), .monSelect(monSelect),
        .applyStrobe(applyStrobe), .applyGroup(applyGroup), .applyIndex(applyIndex),
        .applyValue(applyValue));

    // Code view: group letter, two zeros, one-based index.
    function automatic logic [21:0] cv(input logic [2:0] g, input logic [2:0] i);
        return {g != 3'h0, 1'b0, 5'h0A + {2'h0, g}, 5'h00, 5'h00, {2'h0, i} + 5'h01};
    endfunction

    function automatic logic [21:0] dv(input logic pmi, input logic [15:0] v);
        return {pmi, 1'b1, 1'b0, v[15:12], 1'b0, v[11:8], 1'b0, v[7:4], 1'b0, v[3:0]};
    endfunction

    task automatic step(input int key, input logic [21:0] exp);
        viewQ.push_back(exp);
        op.press(key, 4);
    endtask

    task automatic give_verdict;
        if (error_cnt == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------------
    // Output watcher
    // ----------------------------------------------------------------------
    // A note is popped once into expNote, so a mismatch cannot consume a second one.
    always @(negedge clock)
    begin
        if (sys_rst)
            prevView = cv(3'h0, 3'h0);
        else
        begin
            cur = {programModeIndicator, showingData, dispChars};
            if (cur !== prevView)
            begin
                if (viewQ.size() == 0)
                    `CHK(cur, ~cur)
                else
                begin
                    expNote = viewQ.pop_front();
                    `CHK(cur, expNote)
                end
                prevView = cur;
            end
            if (applyStrobe === 1'b1)
            begin
                if (applyQ.size() == 0)
                    `CHK(applyStrobe, 1'b0)
                else
                begin
                    expNote = applyQ.pop_front();
                    `CHK({applyGroup, applyIndex, applyValue}, expNote)
                end
            end
        end
    end

    initial
    begin
        repeat (5000) @(negedge clock);
        error_cnt++;
        give_verdict();
    end

    // ----------------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------------
    initial
    begin
        void'($urandom(17890));
        monData = {4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10)};
        repeat (10) @(negedge clock);
        sys_rst = 1'b0;
        @(negedge clock);
        `CHK({programModeIndicator, showingData, dispChars}, cv(3'h0, 3'h0))
        for (int g = 1; g <= 8; g++)
            step(ESC, cv(3'(g % 8), 3'h0));
        step(UP, cv(3'h0, 3'h1));
        `CHK(monSelect, 3'h1)
        step(DN, cv(3'h0, 3'h0));
        step(DN, cv(3'h0, 3'h7));
        step(UP, cv(3'h0, 3'h0));
        step(SET, dv(1'b0, monData));
        op.press(UP, 4);
        step(SET, cv(3'h0, 3'h0));
        // Main-profile code acts on every step and is restored on cancel.
        step(ESC, cv(3'h1, 3'h0));
        step(SET, dv(1'b1, 16'h0000));
        `CHK(dataBlink, 1'b0)
        applyQ.push_back({kmn_pkg::GRP_MAIN, 3'h0, 16'h0001});
        step(UP, dv(1'b1, 16'h0001));
        applyQ.push_back({kmn_pkg::GRP_MAIN, 3'h0, 16'h0000});
        step(ESC, cv(3'h1, 3'h0));
        // The excepted profile code waits for set and blinks like the non-immediate program codes.
        for (int k = 1; k <= kmn_pkg::EXCEPTED_PROFILE_IDX; k++)
            step(UP, cv(3'h1, 3'(k)));
        step(SET, dv(1'b1, 16'h0000));
        `CHK(dataBlink, 1'b1)
        step(UP, dv(1'b1, 16'h0001));
        step(ESC, cv(3'h1, kmn_pkg::EXCEPTED_PROFILE_IDX));
        step(ESC, cv(3'h2, 3'h0));
        step(SET, dv(1'b1, 16'h0000));
        `CHK(dataBlink, 1'b1)
        n = 1 + $urandom % 3;
        for (int k = 1; k <= n; k++)
            step(UP, dv(1'b1, 16'(k)));
        step(ESC, cv(3'h2, 3'h0));
        step(SET, dv(1'b1, 16'h0000));
        step(DN, dv(1'b1, 16'h9999));
        applyQ.push_back({kmn_pkg::GRP_STD, 3'h0, 16'h9999});
        step(SET, cv(3'h2, 3'h0));
        step(SET, dv(1'b1, 16'h9999));
        step(UP, dv(1'b1, 16'h0000));
        // Long escape from a pending edit: cancels, steps on each repeat, then lands on the first monitor code.
        viewQ.push_back(cv(3'h2, 3'h0));
        for (int g = 3; g < 3 + (HOLD_T - 1) / REP_T; g++)
            viewQ.push_back(cv(3'(g), 3'h0));
        viewQ.push_back(cv(3'h0, 3'h0));
        op.press(ESC, 60);
        `CHK({programModeIndicator, showingData, dispChars}, cv(3'h0, 3'h0))
        `CHK(viewQ.size(), 0)
        `CHK(viewQ.size() + applyQ.size(), 0)
        give_verdict();
    end
endmodule
